// ==== sfps_consts.svh ====
// Constants of the serial flash program sequencer: command codes, sizes, counts.
// Assumes inclusion by bare name from the sequencer module.
`ifndef SFPS_CONSTS_SVH
`define SFPS_CONSTS_SVH

`define SFPS_CMD_WREN      8'h06
`define SFPS_CMD_WRDI      8'h04
`define SFPS_CMD_SEQ_A     8'had
`define SFPS_CMD_SEQ_B     8'haf
`define SFPS_CMD_DUAL      8'ha2
`define SFPS_CMD_QUAD      8'h32
`define SFPS_ADDR_BITS     5'd24
`define SFPS_ARRAY_TOP     20'hfffff
`define SFPS_PAGE_BYTES    9'h100
`define SFPS_FIFO_DEPTH    16
`define SFPS_FIFO_WIDTH    32
`define SFPS_PIN_IDLE      6'h21

`endif

// ==== sfps_pkg.sv ====
// Types shared by the serial flash program sequencer modules.
// Assumes nothing; the constants header is not used here.
`default_nettype none
package sfps_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_SKIP, ST_EMIT} sfps_state_e;
  typedef enum logic [2:0] {OP_NONE, OP_WREN, OP_WRDI, OP_SEQ, OP_DUAL, OP_QUAD} sfps_op_e;
endpackage
`default_nettype wire

// ==== sfps_sync.sv ====
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
module sfps_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      meta_reg <= RST;
      o_sync   <= RST;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== sfps_fifo.sv ====
// Program request FIFO with registered output stage.
// Assumes a single clock; the drain side may stall by holding i_out_ready low.
`timescale 1ns/1ps
`default_nettype none
module sfps_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data,
  output logic              o_empty
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  wire           push = i_in_valid & o_in_ready;
  wire           pop  = ~o_empty & (~o_out_valid | i_out_ready);

  assign o_in_ready = (cnt_reg != D[AW:0]);
  assign o_empty    = (cnt_reg == '0);

  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[wr_reg] <= i_in_data;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      wr_reg      <= '0;
      rd_reg      <= '0;
      cnt_reg     <= '0;
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
      begin
        rd_reg     <= rd_reg + 1'b1;
        o_out_data <= mem[rd_reg];
      end
      if (pop)
        o_out_valid <= 1'b1;
      else if (i_out_ready)
        o_out_valid <= 1'b0;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// ==== sfps_sequencer.sv ====
// Program sequencer: sequential, dual-line and quad-line program commands.
// Assumes serial pins arrive asynchronously; the array side drains requests
// through a FIFO and reports a failed byte with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "sfps_consts.svh"
module sfps_sequencer (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_si,
  input  wire logic        i_so,
  input  wire logic        i_wp,
  input  wire logic        i_hold,
  input  wire logic        i_quad_lines_enable,
  input  wire logic [15:0] i_protected_blocks,
  input  wire logic        i_erase_suspended,
  input  wire logic [3:0]  i_suspended_block,
  input  wire logic        i_prog_fail,
  input  wire logic        i_error_clear,
  input  wire logic        i_prog_ready,
  output logic             o_prog_valid,
  output logic      [23:0] o_prog_addr,
  output logic      [7:0]  o_prog_data,
  output logic             o_write_enable_latch,
  output logic             o_sequential_mode_flag,
  output logic             o_busy_flag,
  output logic             o_erase_error_flag,
  output logic             o_program_error_flag
);
  // ==========================================================
  // Pin sampling
  logic [5:0] pins_s;
  logic       sck_q;
  logic       cs_n_q;

  sfps_sync #(.W(6), .RST(`SFPS_PIN_IDLE)) u_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  ({i_cs_n, i_sck, i_hold, i_wp, i_so, i_si}),
    .o_sync   (pins_s)
  );

  wire cs_n_s    = pins_s[5];
  wire sck_s     = pins_s[4];
  wire hold_s    = pins_s[3];
  wire wp_s      = pins_s[2];
  wire so_s      = pins_s[1];
  wire si_s      = pins_s[0];
  wire sck_rise  = sck_s & ~sck_q & ~cs_n_s;
  wire frm_start = ~cs_n_s & cs_n_q;
  wire frm_end   = cs_n_s & ~cs_n_q;

  // ==========================================================
  // State
  sfps_pkg::sfps_state_e state_reg, state_next;
  sfps_pkg::sfps_op_e    op_reg, op_next;
  logic [7:0]  sh_reg, sh_next;
  logic [2:0]  bit_reg, bit_next;
  logic [4:0]  acnt_reg, acnt_next;
  logic [23:0] addr_reg, addr_next;
  logic [23:0] seq_reg, seq_next;
  logic [7:0]  ptr_reg, ptr_next;
  logic [8:0]  cnt_reg, cnt_next;
  logic        got_reg, got_next;
  logic        wel_reg, wel_next;
  logic        spm_reg, spm_next;
  logic [15:0] em_hi_reg, em_hi_next;
  logic [7:0]  em_idx_reg, em_idx_next;
  logic [8:0]  em_left_reg, em_left_next;
  logic [7:0]  buf_mem [256];
  logic        buf_we;
  logic [7:0]  buf_idx;

  // ==========================================================
  // Lane selection and byte assembly
  wire [2:0] lanes    = (op_reg == sfps_pkg::OP_QUAD) ? 3'd4 :
                        (op_reg == sfps_pkg::OP_DUAL) ? 3'd2 : 3'd1;
  wire [7:0] sh_one   = {sh_reg[6:0], si_s};
  wire [7:0] sh_two   = {sh_reg[5:0], so_s, si_s};
  wire [7:0] sh_four  = {sh_reg[3:0], hold_s, wp_s, so_s, si_s};
  wire       in_data  = (state_reg == sfps_pkg::ST_DATA);
  wire [7:0] sh_lane  = !in_data ? sh_one :
                        (lanes == 3'd4) ? sh_four : (lanes == 3'd2) ? sh_two : sh_one;
  wire [3:0] bit_sum  = {1'b0, bit_reg} + {1'b0, (in_data ? lanes : 3'd1)};
  wire       byte_end = bit_sum[3];
  wire [23:0] addr_sh = {addr_reg[22:0], si_s};

  // Block checks on the 1 MB array, 64 kB blocks
  wire [19:0] seq_inc  = seq_reg[19:0] + 20'h1;
  wire        at_top   = (seq_reg[19:0] == `SFPS_ARRAY_TOP);
  wire        prot_seq = i_protected_blocks[seq_reg[19:16]];
  wire        prot_nxt = i_protected_blocks[seq_inc[19:16]];
  wire        prot_pg  = i_protected_blocks[addr_reg[19:16]];
  wire        susp_nxt = i_erase_suspended & (seq_inc[19:16] == i_suspended_block);
  wire        frm_ok   = in_data & got_reg & (bit_reg == 3'd0);
  wire        seq_mode_op = (op_reg == sfps_pkg::OP_SEQ);
  wire        page_op  = (op_reg == sfps_pkg::OP_DUAL) | (op_reg == sfps_pkg::OP_QUAD);

  // FIFO feed
  logic fifo_ready;
  logic fifo_empty;
  wire  emit_push = (state_reg == sfps_pkg::ST_EMIT);

  // ==========================================================
  // Next state
  always_comb
  begin
    state_next   = state_reg;
    op_next      = op_reg;
    sh_next      = sh_reg;
    bit_next     = bit_reg;
    acnt_next    = acnt_reg;
    addr_next    = addr_reg;
    seq_next     = seq_reg;
    ptr_next     = ptr_reg;
    cnt_next     = cnt_reg;
    got_next     = got_reg;
    wel_next     = wel_reg;
    spm_next     = spm_reg;
    em_hi_next   = em_hi_reg;
    em_idx_next  = em_idx_reg;
    em_left_next = em_left_reg;
    buf_we       = 1'b0;
    buf_idx      = seq_mode_op ? seq_reg[7:0] : ptr_reg;
    unique case (state_reg)
      sfps_pkg::ST_IDLE:
        if (frm_start)
        begin
          state_next = sfps_pkg::ST_CMD;
          op_next    = sfps_pkg::OP_NONE;
          bit_next   = 3'd0;
          acnt_next  = 5'd0;
          got_next   = 1'b0;
          cnt_next   = 9'd0;
        end
      sfps_pkg::ST_EMIT:
        if (fifo_ready)
        begin
          em_idx_next  = em_idx_reg + 8'h1;
          em_left_next = em_left_reg - 9'd1;
          if (em_left_reg == 9'd1)
            state_next = sfps_pkg::ST_IDLE;
        end
      default:
        if (frm_end)
        begin
          state_next = sfps_pkg::ST_IDLE;
          if (op_reg == sfps_pkg::OP_WREN && state_reg == sfps_pkg::ST_SKIP && bit_reg == 3'd0)
            wel_next = 1'b1;
          else if (op_reg == sfps_pkg::OP_WRDI && bit_reg == 3'd0)
            wel_next = 1'b0;
          else if (seq_mode_op)
          begin
            if (!frm_ok || prot_seq)
              wel_next = 1'b0;
            else
            begin
              state_next   = sfps_pkg::ST_EMIT;
              em_hi_next   = seq_reg[23:8];
              em_idx_next  = seq_reg[7:0];
              em_left_next = 9'd1;
              spm_next     = 1'b1;
              seq_next     = {seq_reg[23:20], seq_inc};
              if (at_top || prot_nxt)
              begin
                spm_next = 1'b0;
                wel_next = 1'b0;
              end
              if (susp_nxt)
                spm_next = 1'b0;
            end
          end
          else if (page_op)
          begin
            if (!frm_ok || prot_pg)
              wel_next = 1'b0;
            else
            begin
              state_next   = sfps_pkg::ST_EMIT;
              em_hi_next   = addr_reg[23:8];
              em_idx_next  = ptr_reg - cnt_reg[7:0];
              em_left_next = cnt_reg;
            end
          end
        end
        else if (sck_rise)
        begin
          sh_next  = sh_lane;
          bit_next = bit_sum[2:0];
          unique case (state_reg)
            sfps_pkg::ST_CMD:
              if (byte_end)
              begin
                state_next = sfps_pkg::ST_SKIP;
                if (sh_one == `SFPS_CMD_WREN)
                  op_next = sfps_pkg::OP_WREN;
                else if (sh_one == `SFPS_CMD_WRDI)
                  op_next = sfps_pkg::OP_WRDI;
                else if ((sh_one == `SFPS_CMD_SEQ_A || sh_one == `SFPS_CMD_SEQ_B) && wel_reg)
                begin
                  op_next    = sfps_pkg::OP_SEQ;
                  state_next = spm_reg ? sfps_pkg::ST_DATA : sfps_pkg::ST_ADDR;
                end
                else if (sh_one == `SFPS_CMD_DUAL && wel_reg && !spm_reg)
                begin
                  op_next    = sfps_pkg::OP_DUAL;
                  state_next = sfps_pkg::ST_ADDR;
                end
                else if (sh_one == `SFPS_CMD_QUAD && wel_reg && !spm_reg && i_quad_lines_enable)
                begin
                  op_next    = sfps_pkg::OP_QUAD;
                  state_next = sfps_pkg::ST_ADDR;
                end
              end
            sfps_pkg::ST_ADDR:
            begin
              addr_next = addr_sh;
              acnt_next = acnt_reg + 5'd1;
              if (acnt_reg == `SFPS_ADDR_BITS - 5'd1)
              begin
                state_next = sfps_pkg::ST_DATA;
                ptr_next   = addr_sh[7:0];
                if (seq_mode_op)
                  seq_next = addr_sh;
              end
            end
            sfps_pkg::ST_DATA:
              if (byte_end)
              begin
                buf_we   = 1'b1;
                got_next = 1'b1;
                ptr_next = ptr_reg + 8'h1;
                if (cnt_reg != `SFPS_PAGE_BYTES)
                  cnt_next = cnt_reg + 9'd1;
              end
            default:
              sh_next = sh_lane;
          endcase
        end
    endcase
    if (!wel_next)
      spm_next = 1'b0;
  end

  // ==========================================================
  // Page buffer
  always_ff @(posedge i_clock)
  begin
    if (buf_we)
      buf_mem[buf_idx] <= sh_lane;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      state_reg   <= sfps_pkg::ST_IDLE;
      op_reg      <= sfps_pkg::OP_NONE;
      sh_reg      <= 8'h00;
      bit_reg     <= 3'h0;
      acnt_reg    <= 5'h00;
      addr_reg    <= 24'h000000;
      seq_reg     <= 24'h000000;
      ptr_reg     <= 8'h00;
      cnt_reg     <= 9'h000;
      got_reg     <= 1'b0;
      wel_reg     <= 1'b0;
      spm_reg     <= 1'b0;
      em_hi_reg   <= 16'h0000;
      em_idx_reg  <= 8'h00;
      em_left_reg <= 9'h000;
      sck_q       <= 1'b0;
      cs_n_q      <= 1'b1;
    end
    else
    begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      sh_reg      <= sh_next;
      bit_reg     <= bit_next;
      acnt_reg    <= acnt_next;
      addr_reg    <= addr_next;
      seq_reg     <= seq_next;
      ptr_reg     <= ptr_next;
      cnt_reg     <= cnt_next;
      got_reg     <= got_next;
      wel_reg     <= wel_next;
      spm_reg     <= spm_next;
      em_hi_reg   <= em_hi_next;
      em_idx_reg  <= em_idx_next;
      em_left_reg <= em_left_next;
      sck_q       <= sck_s;
      cs_n_q      <= cs_n_s;
    end
  end

  // ==========================================================
  // Status outputs
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      o_write_enable_latch   <= 1'b0;
      o_sequential_mode_flag <= 1'b0;
      o_busy_flag            <= 1'b0;
      o_erase_error_flag     <= 1'b0;
      o_program_error_flag   <= 1'b0;
    end
    else
    begin
      o_write_enable_latch   <= wel_next;
      o_sequential_mode_flag <= spm_next;
      o_busy_flag            <= emit_push | ~fifo_empty | o_prog_valid;
      if (i_prog_fail)
      begin
        o_erase_error_flag   <= 1'b1;
        o_program_error_flag <= 1'b1;
      end
      else if (i_error_clear)
      begin
        o_erase_error_flag   <= 1'b0;
        o_program_error_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Program request FIFO
  sfps_fifo #(.W(`SFPS_FIFO_WIDTH), .D(`SFPS_FIFO_DEPTH)) u_fifo (
    .i_clock     (i_clock),
    .i_resetn    (i_resetn),
    .i_in_valid  (emit_push),
    .o_in_ready  (fifo_ready),
    .i_in_data   ({em_hi_reg, em_idx_reg, buf_mem[em_idx_reg]}),
    .o_out_valid (o_prog_valid),
    .i_out_ready (i_prog_ready),
    .o_out_data  ({o_prog_addr, o_prog_data}),
    .o_empty     (fifo_empty)
  );
endmodule
`default_nettype wire

// ==== sfps_host.sv ====
// Behavioural SPI host driving chip select, serial clock and four lanes.
// Assumes the bench calls one task at a time; lanes are {hold, wp, so, si}.
`timescale 1ns/1ps
`default_nettype none
module sfps_host (
  output logic       o_cs_n,
  output logic       o_sck,
  output logic [3:0] o_io
);
  // ==========
  // Idle pins
  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_io   = 4'h5;
  end

  // ==========
  // One serial clock; it stands low between frames
  task automatic clk1(input logic [3:0] v);
    o_io = v;
    #24 o_sck = 1'b1;
    #24 o_sck = 1'b0;
  endtask

  // One byte on 1, 2 or 4 lanes, high bit first
  task automatic put(input logic [7:0] b, input int w);
    for (int i = 0; i < 8 / w; i++)
      if (w == 1)
        clk1({~o_io[3:1], b[7 - i]});
      else if (w == 2)
        clk1({~o_io[3:2], b[7 - 2 * i], b[6 - 2 * i]});
      else
        clk1(i ? b[3:0] : b[7:4]);
  endtask

  // Select or release; released lanes show the inverse of their last value
  task automatic sel(input logic on);
    #24 o_cs_n = ~on;
    if (!on)
      o_io = ~o_io;
    #24;
  endtask
endmodule
`default_nettype wire

// ==== sfps_sequencer_chk.sv ====
// Concurrent checks on the sequencer's array side and status flags.
// Assumes it is bound to sfps_sequencer; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sfps_sequencer_chk (
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_cs_n,
  input wire logic        i_prog_fail,
  input wire logic        i_error_clear,
  input wire logic        i_prog_ready,
  input wire logic        o_prog_valid,
  input wire logic [23:0] o_prog_addr,
  input wire logic [7:0]  o_prog_data,
  input wire logic        o_write_enable_latch,
  input wire logic        o_sequential_mode_flag,
  input wire logic        o_busy_flag,
  input wire logic        o_erase_error_flag,
  input wire logic        o_program_error_flag
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  // ==========
  // Array requests
  req_hold_a: assert property (
    o_prog_valid && !i_prog_ready |=> o_prog_valid && $stable(o_prog_addr)
    && $stable(o_prog_data)) else $error("Request changed before taken");
  req_after_cs_a: assert property (
    $rose(o_prog_valid) |-> i_cs_n && $past(i_cs_n, 2))
    else $error("Request while selected");
  valid_busy_a: assert property (
    o_prog_valid |-> o_busy_flag) else $error("Request while not busy");

  // ==========
  // Status flags
  mode_wel_a: assert property (
    o_sequential_mode_flag |-> o_write_enable_latch)
    else $error("Sequential mode without write latch");
  mode_rest_a: assert property (
    $changed(o_sequential_mode_flag) |-> i_cs_n)
    else $error("Mode changed mid frame");
  fail_sets_a: assert property (
    i_prog_fail |=> o_erase_error_flag && o_program_error_flag)
    else $error("Failure not flagged");
  flags_pair_a: assert property (
    o_erase_error_flag == o_program_error_flag) else $error("Error flags differ");
  err_clear_a: assert property (
    i_error_clear && !i_prog_fail |=> !o_program_error_flag)
    else $error("Error flag not cleared");
  err_sticky_a: assert property (
    $fell(o_program_error_flag) |-> $past(i_error_clear) && !$past(i_prog_fail))
    else $error("Error flag fell by itself");
endmodule

bind sfps_sequencer sfps_sequencer_chk u_chk (.i_clock, .i_resetn, .i_cs_n,
  .i_prog_fail, .i_error_clear, .i_prog_ready, .o_prog_valid, .o_prog_addr,
  .o_prog_data, .o_write_enable_latch, .o_sequential_mode_flag, .o_busy_flag,
  .o_erase_error_flag, .o_program_error_flag);
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the program sequencer with a behavioural SPI host.
// Assumes the host model drives the serial pins; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic        cs_n, sck, pv, write_enable_latch, sm, busy, ee, pe;
  logic        qe = 1'b0, susp = 1'b0, fail = 1'b0, eclr = 1'b0;
  logic        rdy = 1'b0, stall = 1'b0;
  logic [3:0]  io;
  logic [3:0]  sblk = 4'h3;
  logic [15:0] prot = 16'h0000;
  logic [23:0] pa, a;
  logic [7:0]  pd, last, b;
  logic [7:0]  img [256];
  logic [31:0] seed = 32'hc45a, rs = 32'hc45a, got [$];
  int          failures = 0, n_tests = 0, cyc = 0;

  always #2.5 i_clock = ~i_clock;

  sfps_host host (.o_cs_n(cs_n), .o_sck(sck), .o_io(io));
  sfps_sequencer dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(io[0]), .i_so(io[1]), .i_wp(io[2]), .i_hold(io[3]),
    .i_quad_lines_enable(qe), .i_protected_blocks(prot), .i_erase_suspended(susp),
    .i_suspended_block(sblk), .i_prog_fail(fail), .i_error_clear(eclr),
    .i_prog_ready(rdy), .o_prog_valid(pv), .o_prog_addr(pa), .o_prog_data(pd),
    .o_write_enable_latch(write_enable_latch), .o_sequential_mode_flag(sm), .o_busy_flag(busy),
    .o_erase_error_flag(ee), .o_program_error_flag(pe));

  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [7:0] rnd();
    seed = xs(seed);
    return seed[7:0];
  endfunction

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Array side takes requests at random and records them
  always @(posedge i_clock)
  begin
    if (pv && rdy)
      got.push_back({pa, pd});
    #1;
    rs = xs(rs);
    rdy = !stall && rs[0];
  end

  // Cycle limit
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic settle();
    repeat (150) @(posedge i_clock);
    stall = 1'b0;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge i_clock);
    #1;
  endtask

  // One frame: command, optional address, n random bytes, cut stray clocks
  task automatic xfer(input logic [7:0] c, input logic [23:0] ad, input logic wa,
                      input int n, input int w, input int cut);
    img = '{default: 8'hxx};
    got.delete();
    host.sel(1'b1);
    host.put(c, 1);
    if (wa)
      for (int k = 2; k >= 0; k--)
        host.put(ad[8 * k +: 8], 1);
    for (int i = 0; i < n; i++)
    begin
      last = rnd();
      img[8'(ad + i)] = last;
      host.put(last, w);
    end
    for (int i = 0; i < cut; i++)
      host.clk1(4'(i));
    host.sel(1'b0);
    settle();
  endtask

  task automatic wren();
    xfer(8'h06, 0, 0, 0, 1, 0);
  endtask

  task automatic pchk(input logic [23:0] ad, input int n);
    logic [7:0] lo;
    chk(got.size(), n > 256 ? 256 : n);
    foreach (got[k])
    begin
      lo = 8'(ad[7:0] + k + (n > 256 ? n - 256 : 0));
      chk(got[k], {ad[23:8], lo, img[lo]});
    end
  endtask

  task automatic res(input int n, input logic [23:0] ad, input logic [1:0] f);
    chk(got.size(), n);
    if (n > 0)
      chk(got[0], {ad, last});
    chk({sm, write_enable_latch}, f);
  endtask

  // ==========
  // Main sequence
  initial
  begin
    repeat (16) @(posedge i_clock);
    #1 i_resetn = 1'b1;
    repeat (6) @(posedge i_clock);
    wren();
    chk(write_enable_latch, 1'b1);
    xfer(8'ha2, 24'h0000fe, 1, 3, 2, 0);
    pchk(24'h0000fe, 3);
    stall = 1'b1;
    xfer(8'ha2, 24'h050100, 1, 258, 2, 0);
    pchk(24'h050100, 258);
    qe = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      b = rnd();
      a = {12'h000, b[3:0], rnd()};
      xfer(r[0] ? 8'ha2 : 8'h32, a, 1, 1 + b[7:4], r[0] ? 2 : 4, 0);
      pchk(a, 1 + b[7:4]);
    end
    qe = 1'b0;
    xfer(8'h32, 24'h000010, 1, 2, 4, 0);
    res(0, 0, 2'b01);
    xfer(8'ha2, 24'h000200, 1, 1, 2, 2);
    res(0, 0, 2'b00);
    prot = 16'h0002;
    wren();
    xfer(8'ha2, 24'h010000, 1, 2, 2, 0);
    res(0, 0, 2'b00);
    wren();
    xfer(8'had, 24'h020010, 1, 2, 1, 0);
    res(1, 24'h020010, 2'b11);
    xfer(8'haf, 0, 0, 1, 1, 0);
    res(1, 24'h020011, 2'b11);
    xfer(8'had, 0, 0, 1, 1, 3);
    res(0, 0, 2'b00);
    wren();
    xfer(8'had, 24'h010005, 1, 1, 1, 0);
    res(0, 0, 2'b00);
    wren();
    xfer(8'had, 24'h00ffff, 1, 1, 1, 0);
    res(1, 24'h00ffff, 2'b00);
    wren();
    xfer(8'haf, 24'h020000, 1, 1, 1, 0);
    res(1, 24'h020000, 2'b11);
    xfer(8'h04, 0, 0, 0, 1, 0);
    res(0, 0, 2'b00);
    prot = 16'h0000;
    wren();
    xfer(8'haf, 24'h0fffff, 1, 1, 1, 0);
    res(1, 24'h0fffff, 2'b00);
    susp = 1'b1;
    wren();
    xfer(8'had, 24'h02ffff, 1, 1, 1, 0);
    res(1, 24'h02ffff, 2'b01);
    susp = 1'b0;
    fail = 1'b1;
    @(posedge i_clock);
    #1 fail = 1'b0;
    @(posedge i_clock);
    #1 chk({ee, pe}, 2'b11);
    eclr = 1'b1;
    @(posedge i_clock);
    #1 eclr = 1'b0;
    @(posedge i_clock);
    #1 chk({ee, pe}, 2'b00);
    wrap_up();
  end
endmodule
`default_nettype wire
